/* core/gptu_top.sv */
`timescale 1ns/100ps
`default_nettype none
module gptu_top (
  // APB slave
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Timer pins
  input wire gptu_pkg::gptu_pins_t pins,
  output logic core_a_toggle_out_pin,
  output logic core_b_toggle_out_pin,
  // To compare unit timers
  output logic core_b_ovf_pulse
);

  gptu_pkg::gptu_state_t s_q, s_d;
  logic [gptu_pkg::NTMR-1:0] wrap_v;
  logic [1:0] aux_pin_ev;
  logic cap_ev;
  logic wr_en;
  logic rd_setup;
  logic [5:0] widx;

  // Prescaler tap: true once every 2^k cycles
  function automatic logic pre_tick(input logic [gptu_pkg::PRE_W-1:0] pre, input logic [3:0] k);
    logic [gptu_pkg::PRE_W-1:0] mask;
    mask = (gptu_pkg::PRE_W'(1) << k) - gptu_pkg::PRE_W'(1);
    return (pre & mask) == mask;
  endfunction

  // Selected edge: bit 0 rising, bit 1 falling
  function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic prev);
    return (sel[0] & cur & ~prev) | (sel[1] & ~cur & prev);
  endfunction

  // One count step; top bit flags overflow or underflow
  function automatic logic [16:0] step(input logic [15:0] v, input logic down);
    if (down) begin
      return {v == 16'h0000, v - 16'h0001};
    end
    return {v == 16'hffff, v + 16'h0001};
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a[7:2] <= gptu_pkg::WIX_FLAGS);
  endfunction

  // Read mux; unmapped words read zero
  function automatic logic [31:0] rd_word(input gptu_pkg::gptu_state_t s, input logic [5:0] w);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (w < gptu_pkg::WIX_CNT0) begin
      r = {16'h0000, s.ctrl[3'(w)]};
    end else if (w < gptu_pkg::WIX_CAP_RELOAD) begin
      r = {16'h0000, s.cnt[3'(w - gptu_pkg::WIX_CNT0)]};
    end else if (w == gptu_pkg::WIX_CAP_RELOAD) begin
      r = {16'h0000, s.cap_reload};
    end else if (w == gptu_pkg::WIX_CAPCTL) begin
      r = {27'h0000000, s.capctl};
    end else if (w == gptu_pkg::WIX_FLAGS) begin
      r = {26'h0000000, s.flags};
    end
    return r;
  endfunction

  assign wr_en = psel & penable & pwrite & addr_ok(paddr);
  assign rd_setup = psel & ~penable;
  assign widx = paddr[7:2];

  // Whole next state; pins are sampled as synchronous to pclk
  always_comb begin
    logic [15:0] ctl;
    logic [2:0] md;
    logic down;
    logic inc;
    logic [3:0] k;
    logic otl_cur;
    logic otl_prv;
    logic [16:0] nx;
    logic lat_ev;
    int j;
    ctl = 16'h0000;
    md = 3'h0;
    down = 1'b0;
    inc = 1'b0;
    k = 4'h0;
    otl_cur = 1'b0;
    otl_prv = 1'b0;
    nx = 17'h00000;
    lat_ev = 1'b0;
    j = 0;
    wrap_v = '0;
    aux_pin_ev = 2'b00;
    s_d = s_q;
    s_d.pre = s_q.pre + gptu_pkg::PRE_W'(1);
    s_d.in_prev = pins.tin;
    s_d.eud_prev = pins.eud;
    s_d.cap_prev = pins.cap;
    s_d.otl_a_prev = s_q.otl_a;
    s_d.otl_b_prev = s_q.otl_b;
    s_d.ovf_b = 1'b0;
    // Clear first so a same-cycle hardware set wins
    if (wr_en && widx == gptu_pkg::WIX_FLAGS) begin
      s_d.flags = s_q.flags & ~pwdata[gptu_pkg::FLAGS_W-1:0];
    end
    // Per-timer count enable and step
    for (int i = 0; i < gptu_pkg::NTMR; i++) begin // RULE_01
      ctl = s_q.ctrl[i];
      md = ctl[gptu_pkg::F_MODE +: 3];
      down = ctl[gptu_pkg::F_DOWN] ^ (ctl[gptu_pkg::F_EUD] & pins.eud[i]); // RULE_08
      k = 4'(ctl[gptu_pkg::F_ISEL +: 3]) + ((i >= gptu_pkg::IX_AUX_B) ? gptu_pkg::PRE_B_BASE
          : gptu_pkg::PRE_A_BASE); // RULE_04 RULE_17
      otl_cur = (i >= gptu_pkg::IX_AUX_B) ? s_q.otl_b : s_q.otl_a;
      otl_prv = (i >= gptu_pkg::IX_AUX_B) ? s_q.otl_b_prev : s_q.otl_a_prev;
      case (md) // RULE_03 RULE_16
        gptu_pkg::MD_TIMER: inc = pre_tick(s_q.pre, k);
        gptu_pkg::MD_GATE_LO: inc = pre_tick(s_q.pre, k) & ~pins.tin[i]; // RULE_06 RULE_07
        gptu_pkg::MD_GATE_HI: inc = pre_tick(s_q.pre, k) & pins.tin[i]; // RULE_06 RULE_07
        gptu_pkg::MD_COUNTER: begin
          // Cores never chain onto their own latch
          if (ctl[gptu_pkg::F_OTLCLK] && i != gptu_pkg::IX_CORE_A && i != gptu_pkg::IX_CORE_B) begin
            inc = edge_hit(ctl[gptu_pkg::F_EDGE +: 2], otl_cur, otl_prv); // RULE_02 RULE_11 RULE_18
          end else begin
            inc = edge_hit(ctl[gptu_pkg::F_EDGE +: 2], pins.tin[i], s_q.in_prev[i]); // RULE_05 RULE_07
          end
        end
        gptu_pkg::MD_INCR: begin
          // A leads B counts up; each edge of either line is one step
          inc = (pins.tin[i] ^ s_q.in_prev[i]) | (pins.eud[i] ^ s_q.eud_prev[i]); // RULE_09
          down = ctl[gptu_pkg::F_DOWN] ^ s_q.in_prev[i] ^ pins.eud[i]; // RULE_09
        end
        default: inc = 1'b0; // RULE_12
      endcase
      if (inc && ctl[gptu_pkg::F_RUN]) begin
        nx = step(s_q.cnt[i], down);
        s_d.cnt[i] = nx[15:0];
        wrap_v[i] = nx[16];
        if (nx[16]) begin
          s_d.flags[i] = 1'b1; // RULE_22
        end
      end
    end
    // Output toggle latches
    if (wrap_v[gptu_pkg::IX_CORE_A]) begin
      s_d.otl_a = ~s_q.otl_a; // RULE_10
    end
    if (wrap_v[gptu_pkg::IX_CORE_B]) begin
      s_d.otl_b = ~s_q.otl_b; // RULE_18
      s_d.ovf_b = 1'b1; // RULE_19
      if (s_q.ctrl[gptu_pkg::IX_CORE_B][gptu_pkg::F_LREL]) begin
        s_d.cnt[gptu_pkg::IX_CORE_B] = s_q.cap_reload; // RULE_19
      end
    end
    // Aux A as capture/reload; low slot last so it wins a tie
    for (int n = 0; n < 2; n++) begin
      j = (n == 0) ? gptu_pkg::IX_AUX_A_HIGH : gptu_pkg::IX_AUX_A_LOW;
      ctl = s_q.ctrl[j];
      md = ctl[gptu_pkg::F_MODE +: 3];
      aux_pin_ev[j / 2] = edge_hit(ctl[gptu_pkg::F_EDGE +: 2], pins.tin[j], s_q.in_prev[j]);
      // Latch edge seen one cycle after the wrap that made it
      lat_ev = ctl[gptu_pkg::F_LREL] & (s_q.otl_a ^ s_q.otl_a_prev) & (s_q.otl_a ^ ctl[gptu_pkg::F_LPOL]);
      if (md == gptu_pkg::MD_CAPTURE && aux_pin_ev[j / 2]) begin
        s_d.cnt[j] = s_q.cnt[gptu_pkg::IX_CORE_A]; // RULE_13
      end
      if (md == gptu_pkg::MD_RELOAD && (aux_pin_ev[j / 2] || lat_ev)) begin
        s_d.cnt[gptu_pkg::IX_CORE_A] = s_q.cnt[j]; // RULE_14 RULE_15
      end
    end
    // Capture into the capture/reload register
    cap_ev = edge_hit(s_q.capctl[gptu_pkg::C_EDGE +: 2], pins.cap, s_q.cap_prev) // RULE_20
        | (s_q.capctl[gptu_pkg::C_IN] & (pins.tin[gptu_pkg::IX_CORE_A] ^ s_q.in_prev[gptu_pkg::IX_CORE_A]))
        | (s_q.capctl[gptu_pkg::C_EUD] & (pins.eud[gptu_pkg::IX_CORE_A]
        ^ s_q.eud_prev[gptu_pkg::IX_CORE_A])); // RULE_21
    if (cap_ev) begin
      s_d.cap_reload = s_q.cnt[gptu_pkg::IX_AUX_B]; // RULE_20
      s_d.flags[gptu_pkg::FLAG_CAP] = 1'b1; // RULE_22
      if (s_q.capctl[gptu_pkg::C_CLR]) begin
        s_d.cnt[gptu_pkg::IX_AUX_B] = 16'h0000; // RULE_20
      end
    end
    // Software writes override hardware counting in the same cycle
    if (wr_en) begin
      if (widx < gptu_pkg::WIX_CNT0) begin
        s_d.ctrl[3'(widx)] = pwdata[15:0];
      end else if (widx < gptu_pkg::WIX_CAP_RELOAD) begin
        s_d.cnt[3'(widx - gptu_pkg::WIX_CNT0)] = pwdata[15:0];
      end else if (widx == gptu_pkg::WIX_CAP_RELOAD) begin
        s_d.cap_reload = pwdata[15:0];
      end else if (widx == gptu_pkg::WIX_CAPCTL) begin
        s_d.capctl = pwdata[gptu_pkg::CAPCTL_W-1:0];
      end
    end
    // Read data and error captured in the setup phase
    if (rd_setup) begin
      s_d.prdata = pwrite ? 32'h0000_0000 : rd_word(s_q, widx);
      s_d.pslverr = ~addr_ok(paddr);
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
      s_q.ctrl <= {gptu_pkg::NTMR{gptu_pkg::CTRL_RST}};
      s_q.cnt <= {gptu_pkg::NTMR{gptu_pkg::CNT_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Zero-wait slave; data and error come from flops
  assign pready = 1'b1;
  assign prdata = s_q.prdata;
  assign pslverr = s_q.pslverr;
  assign core_a_toggle_out_pin = s_q.otl_a;
  assign core_b_toggle_out_pin = s_q.otl_b;
  assign core_b_ovf_pulse = s_q.ovf_b;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic nwr;
  logic [15:0] c1;
  logic [15:0] c4;
  logic aux_reload;
  assign nwr = ~(psel & penable & pwrite);
  assign c1 = s_q.ctrl[gptu_pkg::IX_CORE_A];
  assign c4 = s_q.ctrl[gptu_pkg::IX_CORE_B];
  // Either auxiliary in reload mode may overwrite core A
  assign aux_reload = (s_q.ctrl[gptu_pkg::IX_AUX_A_LOW][5:3] == gptu_pkg::MD_RELOAD)
      | (s_q.ctrl[gptu_pkg::IX_AUX_A_HIGH][5:3] == gptu_pkg::MD_RELOAD);

  AST_TIMER_TICK: assert property ( // RULE_04
    nwr && !aux_reload && c1 == 16'h0040 && s_q.pre[2:0] == 3'h7
    |=> s_q.cnt[1] == $past(s_q.cnt[1]) + 16'h0001)
    else $error("core A timer missed a divide-by-8 tick");
  AST_GATE_HOLD: assert property ( // RULE_06
    nwr && c4[5:3] == gptu_pkg::MD_GATE_HI && !pins.tin[4] |=> $stable(s_q.cnt[4]))
    else $error("gated timer counted with gate closed");
  AST_PRESC_B: assert property ( // RULE_17
    nwr && c4[6:0] == 7'h58 && s_q.pre[1:0] != 2'h3 |=> $stable(s_q.cnt[4]))
    else $error("core B counted off a divide-by-4 tick");
  AST_OTL_A: assert property ( // RULE_10
    wrap_v[gptu_pkg::IX_CORE_A] |=> core_a_toggle_out_pin != $past(core_a_toggle_out_pin))
    else $error("core A latch did not toggle on wrap");
  AST_OTL_B: assert property ( // RULE_18
    wrap_v[gptu_pkg::IX_CORE_B] |=> core_b_ovf_pulse && core_b_toggle_out_pin != $past(core_b_toggle_out_pin))
    else $error("core B wrap not seen on latch and pulse");
  AST_OVF_ONE: assert property ( // RULE_19
    core_b_ovf_pulse |-> $past(wrap_v[gptu_pkg::IX_CORE_B]))
    else $error("overflow pulse without core B wrap");
  AST_CAP_RELOAD: assert property ( // RULE_20
    cap_ev && nwr |=> s_q.cap_reload == $past(s_q.cnt[3]) && s_q.flags[gptu_pkg::FLAG_CAP])
    else $error("capture register missed aux B value");
  AST_CAPTURE_A: assert property ( // RULE_13
    nwr && s_q.ctrl[2][5:3] == gptu_pkg::MD_CAPTURE && aux_pin_ev[1] |=> s_q.cnt[2] == $past(s_q.cnt[1]))
    else $error("aux high did not capture core A");
  AST_RELOAD_A: assert property ( // RULE_14
    nwr && s_q.ctrl[2][5:3] == gptu_pkg::MD_RELOAD && s_q.ctrl[0][5:3] != gptu_pkg::MD_RELOAD
    && aux_pin_ev[1] |=> s_q.cnt[1] == $past(s_q.cnt[2]))
    else $error("core A not reloaded from aux high");
  AST_FLAG_SET: assert property ( // RULE_22
    |wrap_v |=> (s_q.flags[4:0] & $past(wrap_v)) == $past(wrap_v))
    else $error("wrap did not set its request flag");
  AST_APB_ERR: assert property (
    psel && !penable && !addr_ok(paddr) |=> pslverr)
    else $error("unmapped address not flagged");

  COV_CORE_A_WRAP: cover property (wrap_v[gptu_pkg::IX_CORE_A]);
  COV_PWM_RELOAD: cover property (s_q.ctrl[0][5:3] == gptu_pkg::MD_RELOAD && s_q.ctrl[2][5:3] == gptu_pkg::MD_RELOAD
    && (s_q.otl_a ^ s_q.otl_a_prev));
  COV_CAP_CLEAR: cover property (cap_ev && s_q.capctl[gptu_pkg::C_CLR]);
  COV_INCR: cover property (s_q.ctrl[1][5:3] == gptu_pkg::MD_INCR && wrap_v[1]);

endmodule
`default_nettype wire

/* core/gptu_pkg.sv */
// What this block does
// RULE_01: Five 16-bit timers in two modules.
// RULE_02: Timers may chain within their own module.
// RULE_03: First-module timers: timer, gated, counter, incremental.
// RULE_04: First-module prescaler divides by eight to 1024.
// RULE_05: Counter mode advances on selected input-pin edges.
// RULE_06: Gated mode counts only at gate level.
// RULE_07: One input pin per timer: gate or clock.
// RULE_08: Software direction, optionally inverted by direction pin.
// RULE_09: Incremental mode decodes quadrature A/B into position.
// RULE_10: Core A latch toggles on each wrap, drives pin.
// RULE_11: Core A latch can clock either auxiliary timer.
// RULE_12: Auxiliary as capture/reload register stops counting.
// RULE_13: Capture copies core A on auxiliary pin event.
// RULE_14: Reload loads core A on pin or latch edge.
// RULE_15: Opposite-edge reloads from both auxiliaries give PWM.
// RULE_16: Second-module timers count prescaled clock or external.
// RULE_17: Second-module prescaler divides by four to 512.
// RULE_18: Core B latch toggles on wrap, clocks auxiliary.
// RULE_19: Core B wraps pulse out and reload from capture register.
// RULE_20: Capture pin edge latches aux B, optional clear.
// RULE_21: Capture may also trigger on core A pins.
// RULE_22: Wraps and captures set sticky request flags.
package gptu_pkg;

  localparam int NTMR = 5;
  // Timer slots: aux A low, core A, aux A high, aux B, core B
  localparam int IX_AUX_A_LOW = 0;
  localparam int IX_CORE_A = 1;
  localparam int IX_AUX_A_HIGH = 2;
  localparam int IX_AUX_B = 3;
  localparam int IX_CORE_B = 4;

  // Register word indices (byte address is index times four)
  localparam logic [5:0] WIX_CTRL0 = 6'h00;
  localparam logic [5:0] WIX_CNT0 = 6'h05;
  localparam logic [5:0] WIX_CAP_RELOAD = 6'h0a;
  localparam logic [5:0] WIX_CAPCTL = 6'h0b;
  localparam logic [5:0] WIX_FLAGS = 6'h0c;

  // Timer control fields
  localparam int F_ISEL = 0;
  localparam int F_MODE = 3;
  localparam int F_RUN = 6;
  localparam int F_DOWN = 7;
  localparam int F_EUD = 8;
  localparam int F_EDGE = 9;
  localparam int F_OTLCLK = 11;
  localparam int F_LREL = 12;
  localparam int F_LPOL = 13;

  // Capture/reload control fields
  localparam int C_EDGE = 0;
  localparam int C_CLR = 2;
  localparam int C_IN = 3;
  localparam int C_EUD = 4;
  localparam int CAPCTL_W = 5;
  localparam int FLAG_CAP = 5;
  localparam int FLAGS_W = 6;

  // Mode codes
  localparam logic [2:0] MD_TIMER = 3'h0;
  localparam logic [2:0] MD_COUNTER = 3'h1;
  localparam logic [2:0] MD_GATE_LO = 3'h2;
  localparam logic [2:0] MD_GATE_HI = 3'h3;
  localparam logic [2:0] MD_RELOAD = 3'h4;
  localparam logic [2:0] MD_CAPTURE = 3'h5;
  localparam logic [2:0] MD_INCR = 3'h6;

  // Prescaler: log2 of the division for code zero
  localparam int PRE_W = 10;
  localparam logic [3:0] PRE_A_BASE = 4'h3;
  localparam logic [3:0] PRE_B_BASE = 4'h2;

  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] CNT_RST = 16'h0000;

  typedef struct packed {
    logic [NTMR-1:0] tin;
    logic [NTMR-1:0] eud;
    logic cap;
  } gptu_pins_t;

  typedef struct packed {
    logic [NTMR-1:0][15:0] cnt;
    logic [NTMR-1:0][15:0] ctrl;
    logic [15:0] cap_reload;
    logic [CAPCTL_W-1:0] capctl;
    logic [FLAGS_W-1:0] flags;
    logic [PRE_W-1:0] pre;
    logic [NTMR-1:0] in_prev;
    logic [NTMR-1:0] eud_prev;
    logic cap_prev;
    logic otl_a;
    logic otl_a_prev;
    logic otl_b;
    logic otl_b_prev;
    logic ovf_b;
    logic [31:0] prdata;
    logic pslverr;
  } gptu_state_t;

endpackage

/* tb/gptu_pin_model.sv */
`timescale 1ns/100ps
`default_nettype none
module gptu_pin_model (
  // Clock
  input wire logic pclk,
  // Pins toward the timer unit
  output var gptu_pkg::gptu_pins_t pins
);
  logic [1:0] ph;

  // Quiet pins until a test asks for events
  initial begin
    pins = '0;
    ph = 2'h0;
  end

  // Static level on an input (e=0) or direction (e=1) pin
  task automatic lvl(input bit e, input int i, input logic v);
    @(posedge pclk);
    if (e) pins.eud[i] <= v;
    else pins.tin[i] <= v;
  endtask

  // High pulse of w cycles, slot 5 is the capture pin; w sets how slow
  task automatic pulse(input int i, input int w);
    @(posedge pclk);
    if (i == 5) pins.cap <= 1'b1;
    else pins.tin[i] <= 1'b1;
    repeat (w) @(posedge pclk);
    if (i == 5) pins.cap <= 1'b0;
    else pins.tin[i] <= 1'b0;
    repeat (w) @(posedge pclk);
  endtask

  // Quadrature steps on core A, A leads B when moving forward
  task automatic quad(input bit fwd, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      ph = fwd ? ph + 2'h1 : ph - 2'h1;
      pins.tin[gptu_pkg::IX_CORE_A] <= ph[0] ^ ph[1];
      pins.eud[gptu_pkg::IX_CORE_A] <= ph[1];
      repeat (3) @(posedge pclk);
    end
  endtask
endmodule
`default_nettype wire

/* tb/general_purpose_timer_unit_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module general_purpose_timer_unit_tb;
  localparam logic [31:0] RUN = 32'h1 << gptu_pkg::F_RUN;
  localparam logic [31:0] DOWN = 32'h1 << gptu_pkg::F_DOWN;
  localparam logic [31:0] EUD = 32'h1 << gptu_pkg::F_EUD;
  localparam logic [31:0] RISE = 32'h1 << gptu_pkg::F_EDGE;
  localparam logic [31:0] FALL = 32'h2 << gptu_pkg::F_EDGE;
  localparam logic [31:0] OTL = 32'h1 << gptu_pkg::F_OTLCLK;
  localparam logic [31:0] LREL = 32'h1 << gptu_pkg::F_LREL;
  localparam logic [31:0] LPOL = 32'h1 << gptu_pkg::F_LPOL;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oa, ob, ovf, err, o;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  gptu_pkg::gptu_pins_t pins;
  int mismatches, comparisons, novf, n0, nh;

  gptu_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins),
    .core_a_toggle_out_pin(oa), .core_b_toggle_out_pin(ob), .core_b_ovf_pulse(ovf));
  gptu_pin_model pin (.pclk(pclk), .pins(pins));

  // Clock and wrap-pulse tally
  always #5 pclk = ~pclk;
  always @(posedge pclk) if (ovf === 1'b1) novf <= novf + 1;

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; the wait on pready is bounded
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 50) mismatches++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic [7:0] ad(input logic [5:0] w);
    return {w, 2'b00};
  endfunction
  function automatic logic [7:0] ctl(input int i);
    return ad(gptu_pkg::WIX_CTRL0 + 6'(i));
  endfunction
  function automatic logic [7:0] cnt(input int i);
    return ad(gptu_pkg::WIX_CNT0 + 6'(i));
  endfunction
  function automatic logic [31:0] cw(input int sel, input logic [2:0] md);
    return 32'(sel) | (32'(md) << gptu_pkg::F_MODE);
  endfunction

  // Two counts read exactly 1024 cycles apart, deltas compared
  task automatic span(input int ia, input int ib, input logic [15:0] ea, input logic [15:0] eb);
    logic [15:0] a0, b0;
    apb(1'b0, cnt(ia), 32'h0);
    a0 = rd[15:0];
    apb(1'b0, cnt(ib), 32'h0);
    b0 = rd[15:0];
    repeat (1018) @(posedge pclk);
    apb(1'b0, cnt(ia), 32'h0);
    check(rd[15:0] - a0, ea);
    apb(1'b0, cnt(ib), 32'h0);
    check(rd[15:0] - b0, eb);
  endtask

  // Edges until the core A toggle pin changes; bounded so a stuck pin fails
  task automatic hold(output int c);
    logic v;
    v = oa;
    c = 0;
    while (oa === v && c < 200) begin
      @(posedge pclk);
      c++;
    end
  endtask

  // Hang guard, well above the expected run of about 10k cycles
  initial begin
    #300000;
    mismatches++;
    end_sim();
  end

  initial begin
    logic [15:0] ea, eb;
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, comparisons, novf} = '0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, ctl(0), 32'h0);
    check(rd[15:0], gptu_pkg::CTRL_RST);
    apb(1'b0, cnt(0), 32'h0);
    check(rd[15:0], gptu_pkg::CNT_RST);
    apb(1'b0, 8'h34, 32'h0);
    check({15'h0, err}, 16'h0001);
    // Every prescaler code, software and pin direction, gate open, then gate closed
    pin.lvl(1'b0, 4, 1'b1);
    for (int i = 0; i < 8; i++) begin
      pin.lvl(1'b1, 4, i[1]);
      apb(1'b1, ctl(1), cw(i, gptu_pkg::MD_TIMER) | RUN | (i[0] ? DOWN : 32'h0));
      apb(1'b1, ctl(4), cw(i, gptu_pkg::MD_GATE_HI) | RUN | EUD);
      ea = 16'(1024 >> (3 + i));
      eb = 16'(1024 >> (2 + i));
      span(1, 4, i[0] ? -ea : ea, i[1] ? -eb : eb);
    end
    pin.lvl(1'b0, 4, 1'b0);
    span(1, 4, 16'hffff, 16'h0000);
    // Counter mode wrap, latch toggle, latch-clocked aux low
    apb(1'b1, ctl(1), cw(0, gptu_pkg::MD_COUNTER) | RUN | RISE);
    apb(1'b1, cnt(1), 32'hfffe);
    apb(1'b1, cnt(0), 32'h0);
    apb(1'b1, ctl(0), cw(0, gptu_pkg::MD_COUNTER) | RUN | RISE | FALL | OTL);
    apb(1'b1, ad(gptu_pkg::WIX_FLAGS), 32'h3f);
    o = oa;
    pin.pulse(1, 2);
    pin.pulse(1, 1);
    apb(1'b0, cnt(1), 32'h0);
    check(rd[15:0], 16'h0000);
    check({15'h0, oa ^ o}, 16'h0001);
    apb(1'b0, cnt(0), 32'h0);
    check(rd[15:0], 16'h0001);
    apb(1'b0, ad(gptu_pkg::WIX_FLAGS), 32'h0);
    check(rd[15:0] & 16'h0002, 16'h0002);
    // Aux high captures core A, then reloads it from a pin edge
    pin.pulse(1, 3);
    apb(1'b1, ctl(2), cw(0, gptu_pkg::MD_CAPTURE) | RUN | RISE);
    pin.pulse(2, 2);
    apb(1'b0, cnt(2), 32'h0);
    check(rd[15:0], 16'h0001);
    apb(1'b1, ctl(2), cw(0, gptu_pkg::MD_RELOAD) | RUN | RISE);
    apb(1'b1, cnt(2), 32'h1234);
    pin.pulse(2, 2);
    apb(1'b0, cnt(1), 32'h0);
    check(rd[15:0], 16'h1234);
    check(rd[31:16], 16'h0000);
    apb(1'b0, cnt(2), 32'h0);
    check(rd[15:0], 16'h1234);
    // Quadrature forward then back to the start position
    apb(1'b1, ctl(1), cw(0, gptu_pkg::MD_INCR) | RUN | RISE | FALL);
    apb(1'b1, cnt(1), 32'h0100);
    pin.quad(1'b1, 4);
    apb(1'b0, cnt(1), 32'h0);
    check({15'h0, rd[15:0] > 16'h0100}, 16'h0001);
    pin.quad(1'b0, 4);
    apb(1'b0, cnt(1), 32'h0);
    check(rd[15:0], 16'h0100);
    // Capture pin latches aux B and clears it; then core A pin trigger
    apb(1'b1, ctl(1), 32'h0);
    apb(1'b1, ctl(3), cw(0, gptu_pkg::MD_COUNTER) | RISE);
    apb(1'b1, cnt(3), 32'h0055);
    apb(1'b1, ad(gptu_pkg::WIX_CAPCTL), 32'h5);
    pin.pulse(5, 2);
    apb(1'b0, ad(gptu_pkg::WIX_CAP_RELOAD), 32'h0);
    check(rd[15:0], 16'h0055);
    apb(1'b0, cnt(3), 32'h0);
    check(rd[15:0], 16'h0000);
    apb(1'b1, cnt(3), 32'h0066);
    apb(1'b1, ad(gptu_pkg::WIX_CAPCTL), 32'h8);
    pin.pulse(1, 2);
    apb(1'b0, ad(gptu_pkg::WIX_CAP_RELOAD), 32'h0);
    check(rd[15:0], 16'h0066);
    apb(1'b0, ad(gptu_pkg::WIX_FLAGS), 32'h0);
    check(rd[15:0] & 16'h0020, 16'h0020);
    // Opposite latch edges reload core A: 2 ticks high, 4 ticks low
    apb(1'b1, cnt(0), 32'hfffe);
    apb(1'b1, cnt(2), 32'hfffc);
    apb(1'b1, ctl(0), cw(0, gptu_pkg::MD_RELOAD) | LREL);
    apb(1'b1, ctl(2), cw(0, gptu_pkg::MD_RELOAD) | LREL | LPOL);
    apb(1'b1, cnt(1), 32'hfff0);
    apb(1'b1, ctl(1), cw(0, gptu_pkg::MD_TIMER) | RUN);
    hold(nh);
    o = oa;
    hold(nh);
    check(16'(nh), o ? 16'h0010 : 16'h0020);
    hold(nh);
    check(16'(nh), o ? 16'h0020 : 16'h0010);
    // Core B wrap: reload from capture register, latch, pulse out
    apb(1'b1, ctl(4), cw(0, gptu_pkg::MD_COUNTER) | RUN | RISE | LREL);
    apb(1'b1, cnt(4), 32'hffff);
    o = ob;
    n0 = novf;
    pin.pulse(4, 2);
    apb(1'b0, cnt(4), 32'h0);
    check(rd[15:0], 16'h0066);
    check({15'h0, ob ^ o}, 16'h0001);
    check(16'(novf - n0), 16'h0001);
    end_sim();
  end
endmodule
`default_nettype wire
